// [pdg_gpio.sv]
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// - Timer 0 compare A drives PD6 when enabled; direction bit still gates it.
// - Timer 0 compare B drives PD5 when enabled; direction bit still gates it.
// - Timer 2 compare B drives PD3 when enabled; direction bit still gates it.
// - Transmitter enabled forces PD1 output, pull-up off, value from transmit data.
// - Receiver enabled forces PD0 input; pull-up follows data bit and global disable.
// - PD4 feeds serial clock and timer 0 count; sync mode drives serial clock out; direction bit still gates it.
// - PD0..7 feed pin-change 16..23; mask and group enable force input on.
// - PD3/PD2 feed external irq 1/0; irq or pin-change enable forces input on.
// - PD5 feeds timer 1 count input without any pull-up or direction override.
// - Port B and D data and direction are 8-bit RW, reset to zero.
// - Pin-input registers are read-only and return pin levels after the two-stage synchroniser.
// - Port C has bits 0..6 only; bit 7 reads as zero.
module pdg_gpio (
    input  wire logic        clk,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Pins
    input  wire logic [7:0]  pb_in,
    output logic [7:0]       pb_out,
    output logic [7:0]       pb_oe,
    output logic [7:0]       pb_pullup,
    input  wire logic [7:0]  pc_in,
    output logic [7:0]       pc_out,
    output logic [7:0]       pc_oe,
    output logic [7:0]       pc_pullup,
    input  wire logic [7:0]  pd_in,
    output logic [7:0]       pd_out,
    output logic [7:0]       pd_oe,
    output logic [7:0]       pd_pullup,
    output logic [7:0]       pd_input_enable,
    // Peripheral side
    input  wire logic        timer0_compare_a_en,
    input  wire logic        timer0_compare_a_out,
    input  wire logic        timer0_compare_b_en,
    input  wire logic        timer0_compare_b_out,
    input  wire logic        timer2_compare_b_en,
    input  wire logic        timer2_compare_b_out,
    input  wire logic        serial_transmitter_enable,
    input  wire logic        serial_tx_data,
    input  wire logic        serial_receiver_enable,
    input  wire logic        serial_mode_select,
    input  wire logic        serial_clock_out,
    input  wire logic        external_irq_0_enable,
    input  wire logic        external_irq_1_enable,
    output logic             serial_rx_data,
    output logic             serial_external_clock,
    output logic             timer0_count_input,
    output logic             timer1_count_input,
    output logic             external_irq_0,
    output logic             external_irq_1,
    output logic [7:0]       pin_change_sources,
    output logic [7:0]       pcmask_out
);
    import pdg_pkg::*;

    // Output-data latches and direction bits of the three ports
    logic [7:0]            pb_port_q;
    logic [7:0]            pb_dir_q;
    logic [7:0]            pc_port_q;
    logic [7:0]            pc_dir_q;
    logic [7:0]            pd_port_q;
    logic [7:0]            pd_dir_q;
    // Control bits and pin-change mask
    logic [PDG_CTRL_W-1:0] ctrl_q;
    logic [7:0]            pcmask_q;
    // Synchroniser flops, first and second stage per port
    logic [7:0]            pb_s1_q;
    logic [7:0]            pb_s2_q;
    logic [7:0]            pc_s1_q;
    logic [7:0]            pc_s2_q;
    logic [7:0]            pd_s1_q;
    logic [7:0]            pd_s2_q;

    // Bus decode
    wire        wr_en     = psel & penable & pwrite;
    wire        rd_setup  = psel & ~penable & ~pwrite;
    wire        hit       = (paddr <= PDG_ADDR_PCMASK) && (paddr[1:0] == 2'h0);
    wire [7:0]  wbyte     = pwdata[7:0];
    wire        pull_dis  = ctrl_q[PDG_CTRL_PULL_DIS];
    wire        pce2      = ctrl_q[PDG_CTRL_PCE2];

    // Write strobes, one per register; pin registers have none
    wire        wr_pb_out = wr_en && (paddr == PDG_ADDR_PB_OUT);
    wire        wr_pb_dir = wr_en && (paddr == PDG_ADDR_PB_DIR);
    wire        wr_pc_out = wr_en && (paddr == PDG_ADDR_PC_OUT);
    wire        wr_pc_dir = wr_en && (paddr == PDG_ADDR_PC_DIR);
    wire        wr_pd_out = wr_en && (paddr == PDG_ADDR_PD_OUT);
    wire        wr_pd_dir = wr_en && (paddr == PDG_ADDR_PD_DIR);
    wire        wr_ctrl   = wr_en && (paddr == PDG_ADDR_CTRL);
    wire        wr_pcmask = wr_en && (paddr == PDG_ADDR_PCMASK);

    // Default pull-up for an input pin
    function automatic logic [7:0] pdg_pull(input logic [7:0] port, input logic [7:0] dir,
                                            input logic dis);
        pdg_pull = port & ~dir & {8{~dis}};
    endfunction : pdg_pull

    // Zero-wait APB answer; unmapped or unaligned access flags an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // Port B latch and direction
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pb_port_q <= PDG_PORT_RST;
            pb_dir_q  <= PDG_PORT_RST;
        end else begin
            if (wr_pb_out) pb_port_q <= wbyte;
            if (wr_pb_dir) pb_dir_q  <= wbyte;
        end
    end

    // Port C latch and direction; bit 7 never stores a one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_port_q <= PDG_PORT_RST;
            pc_dir_q  <= PDG_PORT_RST;
        end else begin
            if (wr_pc_out) pc_port_q <= wbyte & PDG_PC_MASK;
            if (wr_pc_dir) pc_dir_q  <= wbyte & PDG_PC_MASK;
        end
    end

    // Port D latch and direction
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pd_port_q <= PDG_PORT_RST;
            pd_dir_q  <= PDG_PORT_RST;
        end else begin
            if (wr_pd_out) pd_port_q <= wbyte;
            if (wr_pd_dir) pd_dir_q  <= wbyte;
        end
    end

    // Control bits and pin-change mask
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q   <= PDG_CTRL_RST[PDG_CTRL_W-1:0];
            pcmask_q <= PDG_PORT_RST;
        end else begin
            if (wr_ctrl)   ctrl_q   <= wbyte[PDG_CTRL_W-1:0];
            if (wr_pcmask) pcmask_q <= wbyte;
        end
    end

    // Port B pin synchroniser
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pb_s1_q <= PDG_PORT_RST;
            pb_s2_q <= PDG_PORT_RST;
        end else begin
            pb_s1_q <= pb_in;
            pb_s2_q <= pb_s1_q;
        end
    end

    // Port C pin synchroniser; the missing bit 7 is held low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_s1_q <= PDG_PORT_RST;
            pc_s2_q <= PDG_PORT_RST;
        end else begin
            pc_s1_q <= pc_in & PDG_PC_MASK;
            pc_s2_q <= pc_s1_q;
        end
    end

    // Port D pin synchroniser; peripherals only see the second stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pd_s1_q <= PDG_PORT_RST;
            pd_s2_q <= PDG_PORT_RST;
        end else begin
            pd_s1_q <= pd_in;
            pd_s2_q <= pd_s1_q;
        end
    end

    // Read mux over register state
    logic [7:0] rd_d;
    always_comb begin
        case (paddr)
            PDG_ADDR_PB_OUT: rd_d = pb_port_q;
            PDG_ADDR_PB_DIR: rd_d = pb_dir_q;
            PDG_ADDR_PB_PIN: rd_d = pb_s2_q;
            PDG_ADDR_PC_OUT: rd_d = pc_port_q & PDG_PC_MASK;
            PDG_ADDR_PC_DIR: rd_d = pc_dir_q & PDG_PC_MASK;
            PDG_ADDR_PC_PIN: rd_d = pc_s2_q & PDG_PC_MASK;
            PDG_ADDR_PD_OUT: rd_d = pd_port_q;
            PDG_ADDR_PD_DIR: rd_d = pd_dir_q;
            PDG_ADDR_PD_PIN: rd_d = pd_s2_q;
            PDG_ADDR_CTRL:   rd_d = {{(8-PDG_CTRL_W){1'b0}}, ctrl_q};
            PDG_ADDR_PCMASK: rd_d = pcmask_q;
            default:         rd_d = PDG_PORT_RST;
        endcase
    end

    // Read data captured at the end of the setup phase, so it leaves a flip-flop
    logic [7:0] rdata_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= PDG_PORT_RST;
        end else if (rd_setup) begin
            rdata_q <= rd_d;
        end else if (!psel) begin
            rdata_q <= PDG_PORT_RST;
        end
    end
    assign prdata = {24'h000000, rdata_q};

    // Ports B and C: plain drive, no override
    assign pb_oe     = pb_dir_q;
    assign pb_out    = pb_port_q & pb_dir_q;
    assign pb_pullup = pdg_pull(pb_port_q, pb_dir_q, pull_dis);
    assign pc_oe     = pc_dir_q & PDG_PC_MASK;
    assign pc_out    = pc_port_q & pc_dir_q & PDG_PC_MASK;
    assign pc_pullup = pdg_pull(pc_port_q, pc_dir_q, pull_dis) & PDG_PC_MASK;

    // Port D override signals
    logic [7:0] val_ovr_en;                          // Value override enable
    logic [7:0] val_ovr_val;                         // Value override value
    logic [7:0] dir_ovr_en;                          // Direction override enable
    logic [7:0] dir_ovr_val;                         // Direction override value
    logic [7:0] pull_ovr_en;                         // Pull-up override enable
    logic [7:0] pull_ovr_val;                        // Pull-up override value
    logic [7:0] din_force;                           // Digital input forced on
    always_comb begin
        val_ovr_en   = 8'h00;
        val_ovr_val  = 8'h00;
        dir_ovr_en   = 8'h00;
        dir_ovr_val  = 8'h00;
        pull_ovr_en  = 8'h00;
        pull_ovr_val = 8'h00;

        // Timer waveforms take the value only; direction stays with software
        val_ovr_en[PDG_PD_C0A]    = timer0_compare_a_en;
        val_ovr_val[PDG_PD_C0A]   = timer0_compare_a_out;
        val_ovr_en[PDG_PD_C0B]    = timer0_compare_b_en;
        val_ovr_val[PDG_PD_C0B]   = timer0_compare_b_out;
        val_ovr_en[PDG_PD_EIRQ1]  = timer2_compare_b_en;
        val_ovr_val[PDG_PD_EIRQ1] = timer2_compare_b_out;

        // Synchronous serial mode puts the serial clock on its pin value; direction stays with software
        val_ovr_en[PDG_PD_SCLK]   = serial_mode_select;
        val_ovr_val[PDG_PD_SCLK]  = serial_clock_out;

        // Transmitter owns its pin: output, no pull-up, transmit data
        pull_ovr_en[PDG_PD_TX]    = serial_transmitter_enable;
        dir_ovr_en[PDG_PD_TX]     = serial_transmitter_enable;
        dir_ovr_val[PDG_PD_TX]    = 1'b1;
        val_ovr_en[PDG_PD_TX]     = serial_transmitter_enable;
        val_ovr_val[PDG_PD_TX]    = serial_tx_data;

        // Receiver forces input; its pull-up still follows the latch bit
        pull_ovr_en[PDG_PD_RX]    = serial_receiver_enable;
        pull_ovr_val[PDG_PD_RX]   = pd_port_q[PDG_PD_RX] & ~pull_dis;
        dir_ovr_en[PDG_PD_RX]     = serial_receiver_enable;

        // Pin-change and irq enables keep the digital input alive
        din_force                 = pcmask_q & {8{pce2}};
        din_force[PDG_PD_EIRQ1]   = din_force[PDG_PD_EIRQ1] | external_irq_1_enable;
        din_force[PDG_PD_EIRQ0]   = din_force[PDG_PD_EIRQ0] | external_irq_0_enable;
    end

    // Port D pin drive after overrides, one slice per pin
    logic [7:0] pd_dir_eff;
    logic [7:0] pd_val_eff;
    logic [7:0] pd_pull_dflt;
    assign pd_pull_dflt = pdg_pull(pd_port_q, pd_dir_q, pull_dis);
    for (genvar gi = 0; gi < $bits(pd_port_q); gi++) begin : g_pd_pin
        // Direction: override value when enabled, else the direction bit
        assign pd_dir_eff[gi] = dir_ovr_en[gi] ? dir_ovr_val[gi] : pd_dir_q[gi];
        // Value: peripheral value when enabled, else the latch bit
        assign pd_val_eff[gi] = val_ovr_en[gi] ? val_ovr_val[gi] : pd_port_q[gi];
        // Pull-up: override value when enabled, else the default rule
        assign pd_pullup[gi]  = pull_ovr_en[gi] ? pull_ovr_val[gi] : pd_pull_dflt[gi];
        // A pin shows its value only while it drives
        assign pd_oe[gi]      = pd_dir_eff[gi];
        assign pd_out[gi]     = pd_val_eff[gi] & pd_dir_eff[gi];
    end : g_pd_pin
    assign pd_input_enable = din_force;
    assign pcmask_out      = pcmask_q;

    // Synchronised inputs to peripherals
    assign pin_change_sources    = pd_s2_q;
    assign serial_rx_data        = pd_s2_q[PDG_PD_RX];
    assign serial_external_clock = pd_s2_q[PDG_PD_SCLK];
    assign timer0_count_input    = pd_s2_q[PDG_PD_SCLK];
    assign timer1_count_input    = pd_s2_q[PDG_PD_C0B];
    assign external_irq_0        = pd_s2_q[PDG_PD_EIRQ0];
    assign external_irq_1        = pd_s2_q[PDG_PD_EIRQ1];

endmodule : pdg_gpio

// [pdg_pkg.sv]
package pdg_pkg;

    // Register byte addresses on the APB
    localparam logic [7:0] PDG_ADDR_PB_OUT     = 8'h00;
    localparam logic [7:0] PDG_ADDR_PB_DIR     = 8'h04;
    localparam logic [7:0] PDG_ADDR_PB_PIN     = 8'h08;
    localparam logic [7:0] PDG_ADDR_PC_OUT     = 8'h0C;
    localparam logic [7:0] PDG_ADDR_PC_DIR     = 8'h10;
    localparam logic [7:0] PDG_ADDR_PC_PIN     = 8'h14;
    localparam logic [7:0] PDG_ADDR_PD_OUT     = 8'h18;
    localparam logic [7:0] PDG_ADDR_PD_DIR     = 8'h1C;
    localparam logic [7:0] PDG_ADDR_PD_PIN     = 8'h20;
    localparam logic [7:0] PDG_ADDR_CTRL       = 8'h24;
    localparam logic [7:0] PDG_ADDR_PCMASK     = 8'h28;

    // Reset values
    localparam logic [7:0] PDG_PORT_RST = 8'h00;
    localparam logic [7:0] PDG_CTRL_RST = 8'h00;

    // Port C implements bits 0..6 only
    localparam logic [7:0] PDG_PC_MASK = 8'h7F;

    // Control register fields
    localparam int PDG_CTRL_PULL_DIS = 0;
    localparam int PDG_CTRL_PCE2 = 1;
    localparam int PDG_CTRL_W    = 2;

    // Port D pin positions
    localparam int PDG_PD_RX   = 0;
    localparam int PDG_PD_TX   = 1;
    localparam int PDG_PD_EIRQ0 = 2;
    localparam int PDG_PD_EIRQ1 = 3;
    localparam int PDG_PD_SCLK  = 4;
    localparam int PDG_PD_C0B  = 5;
    localparam int PDG_PD_C0A  = 6;

    localparam int PDG_SYNC_STAGES = 2;

endpackage : pdg_pkg

// [pdg_pin_model.sv]
`timescale 1ns/100ps
module pdg_pin_model (
    input  wire logic       clk,
    input  wire logic [7:0] pd_out,
    input  wire logic [7:0] pd_oe,
    input  wire logic [7:0] pd_pullup,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output logic [7:0]      pd_in
);
    logic [7:0] flt_q = 8'h55;
    // Undriven pins without pull-up wander every cycle
    always @(posedge clk) flt_q <= ~flt_q;
    // Port drive first, then outside drive, then pull-up
    assign pd_in = (pd_oe & pd_out) | (~pd_oe & ext_en & ext_val)
                 | (~pd_oe & ~ext_en & (pd_pullup | flt_q));
endmodule : pdg_pin_model

// [pdg_gpio_props.sv]
`timescale 1ns/100ps
module pdg_gpio_props (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [7:0] pd_in,
    input wire logic [7:0] pd_out,
    input wire logic [7:0] pd_oe,
    input wire logic [7:0] pd_pullup,
    input wire logic [7:0] pd_input_enable,
    input wire logic       timer0_compare_a_en,
    input wire logic       timer0_compare_a_out,
    input wire logic       serial_transmitter_enable,
    input wire logic       serial_tx_data,
    input wire logic       serial_receiver_enable,
    input wire logic       external_irq_0_enable,
    input wire logic       external_irq_1_enable,
    input wire logic       external_irq_0,
    input wire logic       external_irq_1,
    input wire logic       timer1_count_input,
    input wire logic [7:0] pin_change_sources,
    input wire logic [7:0] pcmask_out
);
    logic [1:0] up_q;
    // Edges since reset, so the synchroniser check waits for real samples
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_tx; serial_transmitter_enable |-> pd_oe[1] && !pd_pullup[1]
        && pd_out[1] == serial_tx_data; endproperty
    a_tx: assert property (p_tx) else $error("tx override");
    property p_rx; serial_receiver_enable |-> !pd_oe[0]; endproperty
    a_rx: assert property (p_rx) else $error("rx override");
    property p_oca; timer0_compare_a_en && pd_oe[6] |-> pd_out[6] == timer0_compare_a_out;
    endproperty
    a_oca: assert property (p_oca) else $error("compare a");
    property p_sync; up_q == 2'h3 |-> pin_change_sources == $past(pd_in, 2); endproperty
    a_sync: assert property (p_sync) else $error("sync delay");
    property p_tap; external_irq_0 == pin_change_sources[2] && timer1_count_input ==
        pin_change_sources[5] && external_irq_1 == pin_change_sources[3]; endproperty
    a_tap: assert property (p_tap) else $error("input taps");
    property p_ie; external_irq_1_enable |-> pd_input_enable[3]; endproperty
    a_ie: assert property (p_ie) else $error("irq input");
    property p_pcm; (pd_input_enable & ~(pcmask_out | {4'h0, external_irq_1_enable,
        external_irq_0_enable, 2'h0})) == 8'h00; endproperty
    a_pcm: assert property (p_pcm) else $error("input enable");
    property p_pu; (pd_pullup & pd_oe) == 8'h00; endproperty
    a_pu: assert property (p_pu) else $error("pull-up on output");
    c_tx: cover property (serial_transmitter_enable && pd_oe[1]);
    c_oca: cover property (timer0_compare_a_en && pd_oe[6]);
    c_ie: cover property (pd_input_enable == 8'hFF);
endmodule : pdg_gpio_props
bind pdg_gpio pdg_gpio_props u_props (.*);

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import pdg_pkg::*;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr, pb_in, pc_in, pd_in, pb_out, pb_oe, pb_pullup, pc_out, pc_oe, pc_pullup;
    logic [7:0] pd_out, pd_oe, pd_pullup, pd_input_enable, pin_change_sources, pcmask_out;
    logic [7:0] ext_val, ext_en, dr, ou, ct, pm, eo;
    logic [31:0] pwdata, prdata, rd;
    logic timer0_compare_a_en, timer0_compare_a_out, timer0_compare_b_en, timer0_compare_b_out;
    logic timer2_compare_b_en, timer2_compare_b_out, serial_transmitter_enable, serial_tx_data;
    logic serial_receiver_enable, serial_mode_select, serial_clock_out, external_irq_0_enable;
    logic external_irq_1_enable, serial_rx_data, serial_external_clock, timer0_count_input;
    logic timer1_count_input, external_irq_0, external_irq_1;
    logic [12:0] pr;
    int bad_count, num_checks;
    // Peripheral override controls from one random word
    assign {timer0_compare_a_en, timer0_compare_a_out, timer0_compare_b_en, timer0_compare_b_out,
        timer2_compare_b_en, timer2_compare_b_out, serial_transmitter_enable, serial_tx_data,
        serial_receiver_enable, serial_mode_select, serial_clock_out, external_irq_0_enable,
        external_irq_1_enable} = pr;
    pdg_gpio uut (.*);
    pdg_pin_model pins (.*);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // One APB transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        logic rdy;
        n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        // Answer sampled 1 ns after the edge that raises penable, ahead of the edge that completes it
        do begin
            #1;
            rdy = pready;
            rd = prdata;
            er = pslverr;
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 16);
        if (rdy !== 1'b1) bad_count++;
        {psel, penable} <= 2'b00;
    endtask : apb
    function automatic logic [7:0] e_oe(input logic [7:0] d, input logic [12:0] p);
        return (d | {6'h00, p[6], 1'b0}) & ~{7'h00, p[4]};
    endfunction : e_oe
    function automatic logic [7:0] e_out(input logic [7:0] o, d, input logic [12:0] p);
        logic [7:0] v;
        v = o;
        v[6] = p[12] ? p[11] : o[6];
        v[5] = p[10] ? p[9] : o[5];
        v[3] = p[8] ? p[7] : o[3];
        v[4] = p[3] ? p[2] : o[4];
        v[1] = p[6] ? p[5] : o[1];
        return v & e_oe(d, p);
    endfunction : e_out
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pb_in, pc_in, ext_val, ext_en, pr} = '0;
        {bad_count, num_checks} = '0;
        nrst = 1'b0;
        void'($urandom(35292));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 44; a += 4) begin
            apb(1'b0, 8'(a), 8'h00);
            if (a % 12 != 8) chk(rd, 0);
        end
        apb(1'b0, 8'h2C, 8'h00);
        chk(er, 1'b1);
        chk(rd, 0);
        for (int i = 0; i < 40; i++) begin
            {dr, ou, ct, pm} = $urandom;
            apb(1'b1, PDG_ADDR_PD_DIR, dr);
            apb(1'b1, PDG_ADDR_PD_OUT, ou);
            apb(1'b1, PDG_ADDR_CTRL, ct);
            apb(1'b1, PDG_ADDR_PCMASK, pm);
            apb(1'b1, PDG_ADDR_PC_DIR, ou);
            apb(1'b0, PDG_ADDR_PC_DIR, 8'h00);
            chk(rd, ou & 8'h7F);
            apb(1'b1, PDG_ADDR_PB_OUT, dr);
            apb(1'b0, PDG_ADDR_PB_OUT, 8'h00);
            chk(rd, dr);
            pr <= (i < 2) ? {13{i[0]}} : 13'($urandom);
            {ext_en, ext_val, pb_in, pc_in} <= {8'hFF, 24'($urandom)};
            repeat (4) @(posedge clk);
            #1;
            eo = e_oe(dr, pr);
            chk(pd_oe, eo);
            chk(pd_out, e_out(ou, dr, pr));
            chk(pd_pullup, ou & ~eo & {8{~ct[0]}});
            chk(pd_input_enable, (pm & {8{ct[1]}}) | {4'h0, pr[0], pr[1], 2'h0});
            apb(1'b0, PDG_ADDR_PD_PIN, 8'h00);
            chk(rd, e_out(ou, dr, pr) | (~eo & ext_val));
            apb(1'b1, PDG_ADDR_PB_PIN, ~pb_in);
            apb(1'b0, PDG_ADDR_PB_PIN, 8'h00);
            chk(rd, pb_in);
            apb(1'b0, PDG_ADDR_PC_PIN, 8'h00);
            chk(rd, pc_in & 8'h7F);
        end
        // Comparator use: software leaves PD6/PD7 as inputs with pull-up off
        pr <= '0;
        apb(1'b1, PDG_ADDR_PD_DIR, 8'h3F);
        apb(1'b1, PDG_ADDR_PD_OUT, 8'h3F);
        #1;
        chk(pd_oe & 8'hC0, 0);
        chk(pd_pullup & 8'hC0, 0);
        give_verdict();
    end
    // Hang guard
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
endmodule : tb_top
